// ---- rtl/frc_pkg.sv ----
// constants, types and offsets for the flash rewrite control block
package frc_pkg;

  // register indices; byte address is four times the index
  localparam logic [17:0] IDX_CTRL0  = 18'h00000;
  localparam logic [17:0] IDX_CTRL1  = 18'h00001;
  localparam logic [17:0] IDX_CTRL4  = 18'h00002;
  localparam logic [17:0] IDX_CMD    = 18'h00003;
  localparam logic [17:0] IDX_ADDR   = 18'h00004;
  localparam logic [17:0] IDX_OPTION = 18'h0FFFF;

  // control 0 fields
  localparam int C0_READY = 0;
  localparam int C0_SRE   = 1;
  localparam int C0_GRE   = 2;
  localparam int C0_PERR  = 6;
  localparam int C0_EERR  = 7;
  // control 1 fields
  localparam int C1_SUB   = 1;
  localparam int C1_B0DIS = 5;
  localparam int C1_B1DIS = 6;
  localparam int C1_RSV1  = 7;
  // control 4 fields
  localparam int C4_SEN   = 0;
  localparam int C4_SREQ  = 1;
  localparam int C4_RDOK  = 6;
  // option byte fields
  localparam int OB_WDT   = 0;
  localparam int OB_OVR   = 2;
  localparam int OB_PROT  = 3;
  localparam int OB_CSP   = 7;
  localparam logic [7:0] OB_RSV_ONES = 8'h72;
  localparam logic [7:0] OB_RESET    = 8'hFF;
  // status register data fields
  localparam int SR_READY = 7;
  localparam int SR_ERASE = 5;
  localparam int SR_PROG  = 4;

  // command codes
  localparam logic [7:0] CMD_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR  = 8'h50;
  localparam logic [7:0] CMD_PROG   = 8'h40;
  localparam logic [7:0] CMD_ERASE  = 8'h20;
  localparam logic [7:0] CMD_CONF   = 8'hD0;

  // block map of the user area
  localparam logic [15:0] BLK0_BASE  = 16'hE000;
  localparam logic [15:0] BLK1_BASE  = 16'hC000;
  localparam logic [15:0] BLKA_BASE  = 16'h2400;
  localparam logic [15:0] BLKB_BASE  = 16'h2800;
  localparam logic [15:0] BLKAB_LEN  = 16'h0400;
  localparam logic [15:0] OPTION_ADR = 16'hFFFF;

  // stored ID locations in order
  localparam int          ID_LEN = 6;
  localparam logic [15:0] ID_ADR0 = 16'hFFDF;
  localparam logic [15:0] ID_ADR1 = 16'hFFE3;
  localparam logic [15:0] ID_ADR2 = 16'hFFEB;
  localparam logic [15:0] ID_ADR3 = 16'hFFE7;
  localparam logic [15:0] ID_ADR4 = 16'hFFF7;
  localparam logic [15:0] ID_ADR5 = 16'hFFFB;

  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SUSPEND_DELAY_NS = 20000;
  localparam logic [11:0] SUSPEND_CYC =
    12'((SUSPEND_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [6:0] {
    ST_ARRAY  = 7'b0000001,
    ST_STATUS = 7'b0000010,
    ST_PDATA  = 7'b0000100,
    ST_ECONF  = 7'b0001000,
    ST_PBUSY  = 7'b0010000,
    ST_EBUSY  = 7'b0100000,
    ST_SUSP   = 7'b1000000
  } frc_state_t;

  typedef enum logic [2:0] {
    BLK_NONE = 3'h0,
    BLK_0    = 3'h1,
    BLK_1    = 3'h2,
    BLK_A    = 3'h3,
    BLK_B    = 3'h4
  } frc_block_t;

endpackage

// ---- rtl/frc_flash_rewrite_control.sv ----
// flash rewrite control: command sequencer, protection, suspend, id check
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module frc_flash_rewrite_control
  import frc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [19:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // flash macro
  output logic             fm_start,
  output logic             fm_erase,
  output logic [15:0]      fm_addr,
  output logic [7:0]       fm_wdata,
  output logic             fm_suspend,
  input  wire logic        fm_done,
  input  wire logic        fm_fail,
  // cpu side
  input  wire logic        irq_req,
  output logic             cpu_hold,
  // serial and parallel programmer
  input  wire logic        serial_mode,
  input  wire logic        parallel_mode,
  input  wire logic        flash_blank,
  input  wire logic        id_rx_valid,
  input  wire logic [7:0]  id_rx_byte,
  input  wire logic [7:0]  id_rd_data,
  output logic [15:0]      id_rd_addr,
  output logic             ser_cmd_accept,
  output logic             par_access_block,
  output logic             boot_select,
  // option byte effects
  output logic             wdt_autostart,
  output logic             csp_enable
);

  typedef struct packed {
    frc_state_t  st;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        sre;
    logic        gre;
    logic        perr;
    logic        eerr;
    logic        sub;
    logic        b0dis;
    logic        b1dis;
    logic        sen;
    logic        sreq;
    logic        rdok;
    logic [15:0] addr;
    logic [7:0]  opt;
    logic [11:0] dly;
    logic        fm_start;
    logic        fm_erase;
    logic [15:0] fm_addr;
    logic [7:0]  fm_wdata;
    logic        fm_susp;
    logic        hold;
    logic [2:0]  id_idx;
    logic        id_bad;
    logic        id_ok;
    logic [15:0] id_addr;
    logic        ser_ok;
    logic        par_blk;
    logic        wdt;
    logic        csp;
    logic        boot;
  } frc_regs_t;

  frc_regs_t q;
  frc_regs_t d;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic hit(input logic [19:0] a, input logic [17:0] idx);
    hit = (a[19:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  function automatic frc_block_t blk_of(input logic [15:0] a);
    if (a >= BLK0_BASE)
      blk_of = BLK_0;
    else if (a >= BLK1_BASE)
      blk_of = BLK_1;
    else if (a >= BLKA_BASE && a < BLKA_BASE + BLKAB_LEN)
      blk_of = BLK_A;
    else if (a >= BLKB_BASE && a < BLKB_BASE + BLKAB_LEN)
      blk_of = BLK_B;
    else
      blk_of = BLK_NONE;
  endfunction

  // refuses blocks outside the user area and locked program blocks
  function automatic logic blk_ok(input logic [15:0] a, input logic g,
                                  input logic d0, input logic d1);
    frc_block_t b;
    b = blk_of(a);
    case (b)
      BLK_0:   blk_ok = g && !d0;
      BLK_1:   blk_ok = g && !d1;
      BLK_A:   blk_ok = 1'b1;
      BLK_B:   blk_ok = 1'b1;
      default: blk_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] id_loc(input logic [2:0] i);
    case (i)
      3'h0:    id_loc = ID_ADR0;
      3'h1:    id_loc = ID_ADR1;
      3'h2:    id_loc = ID_ADR2;
      3'h3:    id_loc = ID_ADR3;
      3'h4:    id_loc = ID_ADR4;
      default: id_loc = ID_ADR5;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic       busy;
  logic       wr;
  logic       rd;
  logic [7:0] wb;
  logic [7:0] srd;
  logic [7:0] c0_rd;
  logic [7:0] c1_rd;
  logic [7:0] c4_rd;
  logic       erase_win;
  logic       dly_done;

  always_comb begin
    d = q;
    busy = (q.st == ST_PBUSY) || (q.st == ST_EBUSY) || (q.st == ST_SUSP);
    wr = psel && penable && q.pready && pwrite;
    rd = psel && penable && !q.pready && !pwrite;
    wb = pwdata[7:0];
    dly_done = (q.dly == SUSPEND_CYC);
    erase_win = (q.st == ST_EBUSY) || (q.st == ST_SUSP);
    srd = 8'h00;
    srd[SR_READY] = !busy;
    srd[SR_ERASE] = q.eerr;
    srd[SR_PROG]  = q.perr;
    c0_rd = 8'h00;
    c0_rd[C0_READY] = !busy;
    c0_rd[C0_SRE]   = q.sre;
    c0_rd[C0_GRE]   = q.gre;
    c0_rd[C0_PERR]  = q.perr;
    c0_rd[C0_EERR]  = q.eerr;
    c1_rd = 8'h00;
    c1_rd[C1_SUB]   = q.sub;
    c1_rd[C1_B0DIS] = q.b0dis;
    c1_rd[C1_B1DIS] = q.b1dis;
    c1_rd[C1_RSV1]  = 1'b1;
    c4_rd = 8'h00;
    c4_rd[C4_SEN]   = q.sen;
    c4_rd[C4_SREQ]  = q.sreq;
    c4_rd[C4_RDOK]  = q.rdok;

    // apb: one wait state, then pready for a single cycle
    d.pready  = psel && penable && !q.pready;
    d.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      d.prdata  = 32'h0000_0000;
      if (hit(paddr, IDX_CTRL0))
        d.prdata[7:0] = c0_rd;
      else if (hit(paddr, IDX_CTRL1))
        d.prdata[7:0] = c1_rd;
      else if (hit(paddr, IDX_CTRL4))
        d.prdata[7:0] = c4_rd;
      else if (hit(paddr, IDX_CMD))
        d.prdata[7:0] = (q.st == ST_STATUS) ? srd : 8'h00;
      else if (hit(paddr, IDX_ADDR))
        d.prdata[15:0] = q.addr;
      else if (hit(paddr, IDX_OPTION))
        d.prdata[7:0] = q.opt;
      else
        d.pslverr = 1'b1;
      if (!rd)
        d.prdata = 32'h0000_0000;
    end

    d.fm_start = 1'b0;
    if (q.dly != SUSPEND_CYC)
      d.dly = q.dly + 12'h001;

    // register writes
    if (wr && hit(paddr, IDX_CTRL0)) begin
      d.sre = wb[C0_SRE];
      d.gre = wb[C0_GRE] && wb[C0_SRE];
    end
    if (wr && hit(paddr, IDX_CTRL1)) begin
      d.sub = wb[C1_SUB] && q.sre;
      if (q.sre) begin
        d.b0dis = wb[C1_B0DIS];
        d.b1dis = wb[C1_B1DIS];
      end
    end
    if (wr && hit(paddr, IDX_CTRL4)) begin
      d.sen = wb[C4_SEN];
      if (q.sen && erase_win)
        d.sreq = wb[C4_SREQ];
    end
    if (wr && hit(paddr, IDX_ADDR))
      d.addr = pwdata[15:0];
    if (wr && hit(paddr, IDX_OPTION))
      d.opt = wb | OB_RSV_ONES;
    if (!q.sre)
      d.sub = 1'b0;

    // command sequencer
    case (q.st)
      ST_ARRAY, ST_STATUS: begin
        if (wr && hit(paddr, IDX_CMD) && q.sre) begin
          case (wb)
            CMD_ARRAY:  d.st = ST_ARRAY;
            CMD_STATUS: d.st = q.sub ? q.st : ST_STATUS;
            CMD_CLEAR: begin
              d.perr = 1'b0;
              d.eerr = 1'b0;
            end
            CMD_PROG:   d.st = ST_PDATA;
            CMD_ERASE:  d.st = ST_ECONF;
            default:    d.st = q.st;
          endcase
        end
      end
      ST_PDATA: begin
        if (wr && hit(paddr, IDX_CMD)) begin
          if (blk_ok(q.addr, q.gre, q.b0dis, q.b1dis)) begin
            d.fm_start = 1'b1;
            d.fm_erase = 1'b0;
            d.fm_addr  = q.addr;
            d.fm_wdata = wb;
            d.st       = ST_PBUSY;
          end else begin
            d.perr = 1'b1;
            d.st   = q.sub ? ST_ARRAY : ST_STATUS;
          end
        end
      end
      ST_ECONF: begin
        if (wr && hit(paddr, IDX_CMD)) begin
          if (wb == CMD_CONF && blk_ok(q.addr, q.gre, q.b0dis, q.b1dis)) begin
            d.fm_start = 1'b1;
            d.fm_erase = 1'b1;
            d.fm_addr  = q.addr;
            d.dly      = 12'h000;
            d.st       = ST_EBUSY;
          end else begin
            d.eerr = 1'b1;
            d.st   = q.sub ? ST_ARRAY : ST_STATUS;
          end
        end
      end
      ST_PBUSY: begin
        if (fm_done) begin
          d.perr = q.perr || fm_fail;
          d.st   = q.sub ? ST_ARRAY : ST_STATUS;
        end
      end
      ST_EBUSY: begin
        if (q.sub && q.sen && irq_req && dly_done)
          d.sreq = 1'b1;
        if (q.sreq && q.sen) begin
          d.st  = ST_SUSP;
          d.dly = 12'h000;
        end else if (fm_done) begin
          d.eerr = q.eerr || fm_fail;
          d.sreq = 1'b0;
          if (!fm_fail && blk_of(q.fm_addr) == blk_of(OPTION_ADR))
            d.opt = OB_RESET;
          d.st   = q.sub ? ST_ARRAY : ST_STATUS;
        end
      end
      ST_SUSP: begin
        if (dly_done)
          d.rdok = 1'b1;
        if (!q.sreq) begin
          d.rdok = 1'b0;
          d.st   = ST_EBUSY;
        end
      end
      default: d.st = ST_ARRAY;
    endcase
    if (!erase_win)
      d.sreq = 1'b0;
    d.fm_susp = (d.st == ST_SUSP);
    // cpu and port pins frozen only in run-from-flash auto operations
    d.hold = q.sub && ((d.st == ST_PBUSY) || (d.st == ST_EBUSY));

    // serial id check, one byte per request, compared against stored copy
    if (!serial_mode) begin
      d.id_idx = 3'h0;
      d.id_bad = 1'b0;
      d.id_ok  = 1'b0;
    end else if (id_rx_valid && q.id_idx != 3'(ID_LEN)) begin
      if (id_rx_byte != id_rd_data)
        d.id_bad = 1'b1;
      d.id_idx = q.id_idx + 3'h1;
      d.id_ok  = (q.id_idx == 3'(ID_LEN - 1)) && !d.id_bad;
    end
    d.id_addr = id_loc(d.id_idx);
    d.ser_ok  = serial_mode && (flash_blank || d.id_ok);
    d.boot    = serial_mode;
    d.par_blk = parallel_mode && !q.opt[OB_PROT] && q.opt[OB_OVR];
    d.wdt     = !q.opt[OB_WDT];
    d.csp     = !q.opt[OB_CSP];
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q       <= '0;
      q.st    <= ST_ARRAY;
      q.opt   <= OB_RESET;
      q.dly   <= SUSPEND_CYC;
      q.id_addr <= ID_ADR0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pready           = q.pready;
  assign prdata           = q.prdata;
  assign pslverr          = q.pslverr;
  assign fm_start         = q.fm_start;
  assign fm_erase         = q.fm_erase;
  assign fm_addr          = q.fm_addr;
  assign fm_wdata         = q.fm_wdata;
  assign fm_suspend       = q.fm_susp;
  assign cpu_hold         = q.hold;
  assign id_rd_addr       = q.id_addr;
  assign ser_cmd_accept   = q.ser_ok;
  assign par_access_block = q.par_blk;
  assign boot_select      = q.boot;
  assign wdt_autostart    = q.wdt;
  assign csp_enable       = q.csp;

endmodule

// ---- dv/frc_props.sv ----
// concurrent checks on the flash rewrite control ports
`timescale 1ns/10ps
module frc_props (
  // watched ports
  input wire logic        clk, nrst, ce, psel, penable, pready, pslverr,
  input wire logic [19:0] paddr,
  input wire logic        fm_start, fm_erase, fm_suspend, serial_mode,
  input wire logic        flash_blank, ser_cmd_accept, boot_select,
  input wire logic        wdt_autostart, csp_enable,
  input wire logic [15:0] fm_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmap_err: assert property (psel && penable && !pready &&
    paddr == 20'h00014 |=> pslverr) else $error("unmapped not refused");
  a_start_pulse: assert property (fm_start |=> !fm_start)
    else $error("start not a pulse");
  a_addr_hold: assert property (!fm_start |-> $stable(fm_addr))
    else $error("target moved without start");
  a_susp_erase: assert property (fm_suspend |-> fm_erase)
    else $error("suspend outside erase");
  a_boot_follow: assert property ($past(nrst) && $past(ce) |->
    boot_select == $past(serial_mode)) else $error("boot select lag");
  a_serial_drop: assert property (!serial_mode |=> !ser_cmd_accept)
    else $error("accept outside serial");
  a_blank_pass: assert property (serial_mode && flash_blank |->
    ##[1:2] ser_cmd_accept) else $error("blank not accepted");
  a_opt_reset: assert property ($rose(nrst) |->
    !wdt_autostart && !csp_enable) else $error("option effects at reset");
endmodule

// ---- dv/frc_flash_model.sv ----
// behavioural flash macro answering program and erase starts
`timescale 1ns/10ps
module frc_flash_model #(
  parameter int PROG_CYC  = 4,
  parameter int ERASE_CYC = 3000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // control from the sequencer, and the fail choice from the bench
  input  wire logic fm_start,
  input  wire logic fm_erase,
  input  wire logic fm_suspend,
  input  wire logic fail_next,
  // completion
  output logic      fm_done,
  output logic      fm_fail
);
  int   left;
  logic tog;
  // erase runs long so a suspend can land in it
  always_ff @(posedge clk) begin
    tog <= ~tog;
    fm_done <= 1'h0;
    if (!nrst) begin
      left <= 0;
      tog <= 1'h0;
    end else if (fm_start) begin
      left <= fm_erase ? ERASE_CYC : PROG_CYC;
    end else if (left > 0 && !fm_suspend) begin
      left <= left - 1;
      fm_done <= left == 1;
    end
  end
  // fail level means nothing outside the done pulse
  assign fm_fail = fm_done ? fail_next : tog;
endmodule

// ---- dv/frc_flash_rewrite_control_tb.sv ----
// self-checking bench for the flash rewrite control block
`timescale 1ns/10ps
module frc_flash_rewrite_control_tb;
  import frc_pkg::*;
  logic clk, nrst, ce, psel, penable, pwrite, pready, pslverr, perr_s;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic fm_start, fm_erase, fm_suspend, fm_done, fm_fail, fail_next, le;
  logic [15:0] fm_addr, id_rd_addr, la, ida [6];
  logic [7:0] fm_wdata, id_rx_byte, id_rd_data, ld;
  logic irq_req, cpu_hold, serial_mode, parallel_mode, flash_blank;
  logic id_rx_valid, ser_cmd_accept, par_access_block, boot_select;
  logic wdt_autostart, csp_enable;
  int fail_count, comparisons, starts, holds, seed;

  frc_flash_rewrite_control uut (.clk(clk), .nrst(nrst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fm_start(fm_start), .fm_erase(fm_erase), .fm_addr(fm_addr),
    .fm_wdata(fm_wdata), .fm_suspend(fm_suspend), .fm_done(fm_done),
    .fm_fail(fm_fail), .irq_req(irq_req), .cpu_hold(cpu_hold),
    .serial_mode(serial_mode), .parallel_mode(parallel_mode),
    .flash_blank(flash_blank), .id_rx_valid(id_rx_valid),
    .id_rx_byte(id_rx_byte), .id_rd_data(id_rd_data),
    .id_rd_addr(id_rd_addr), .ser_cmd_accept(ser_cmd_accept),
    .par_access_block(par_access_block), .boot_select(boot_select),
    .wdt_autostart(wdt_autostart), .csp_enable(csp_enable));
  frc_flash_model fm (.clk(clk), .nrst(nrst), .fm_start(fm_start),
    .fm_erase(fm_erase), .fm_suspend(fm_suspend), .fail_next(fail_next),
    .fm_done(fm_done), .fm_fail(fm_fail));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] stored(logic [15:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  function automatic logic prot(logic [7:0] v);
    return !v[OB_PROT] && v[OB_OVR];
  endfunction
  assign id_rd_data = stored(id_rd_addr);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fm_start === 1'h1) begin
      starts++;
      la = fm_addr;
      ld = fm_wdata;
      le = fm_erase;
    end
    if (cpu_hold === 1'h1) holds++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      fail_count++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic bus(logic w, logic [17:0] i, logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rdat = prdata;
    perr_s = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wait_rdy();
    do begin
      bus(1'h0, IDX_CTRL0, 32'h0);
    end while (rdat[C0_READY] !== 1'h1);
  endtask
  task automatic prog(logic [15:0] a, logic [7:0] d, logic ok, logic f);
    int s0;
    s0 = starts;
    fail_next <= f;
    bus(1'h1, IDX_ADDR, {16'h0, a});
    bus(1'h1, IDX_CMD, {24'h0, CMD_PROG});
    bus(1'h1, IDX_CMD, {24'h0, d});
    wait_rdy();
    chk("starts", 32'(ok), 32'(starts - s0));
    if (ok) chk("target", {16'h0, a}, {16'h0, la});
    if (ok) chk("data", {24'h0, d}, {24'h0, ld});
    if (ok) chk("kind", 32'h0, 32'(le));
    chk("perr", 32'(ok ? f : 1'h1), 32'(rdat[C0_PERR]));
    bus(1'h1, IDX_CMD, {24'h0, CMD_CLEAR});
  endtask
  task automatic erase(logic [15:0] a, logic [7:0] c);
    bus(1'h1, IDX_ADDR, {16'h0, a});
    bus(1'h1, IDX_CMD, {24'h0, CMD_ERASE});
    bus(1'h1, IDX_CMD, {24'h0, c});
  endtask
  task automatic id_tx(logic [7:0] b);
    id_rx_byte <= b;
    id_rx_valid <= 1'h1;
    @(posedge clk);
    id_rx_valid <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    logic [7:0] v;
    logic f;
    int h0;
    seed = 69;
    ida = '{ID_ADR0, ID_ADR1, ID_ADR2, ID_ADR3, ID_ADR4, ID_ADR5};
    {nrst, psel, penable, pwrite, irq_req, serial_mode} = 6'h0;
    {flash_blank, id_rx_valid, fail_next} = 3'h0;
    {ce, parallel_mode} = 2'h3;
    {paddr, pwdata, id_rx_byte} = 60'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    bus(1'h0, IDX_CTRL0, 32'h0);
    chk("ctrl0", 32'h1, rdat);
    bus(1'h0, IDX_CTRL1, 32'h0);
    chk("ctrl1", 32'h80, rdat);
    bus(1'h0, 18'h5, 32'h0);
    chk("unmapped", 32'h1, {rdat[30:0], perr_s});
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      bus(1'h1, IDX_OPTION, {24'h0, v});
      bus(1'h0, IDX_OPTION, 32'h0);
      chk("option", {24'h0, v | OB_RSV_ONES}, rdat);
      chk("protect", 32'(prot(v)), 32'(par_access_block));
      chk("wdt csp", {30'h0, ~v[OB_CSP], ~v[OB_WDT]},
          {30'h0, csp_enable, wdt_autostart});
    end
    bus(1'h1, IDX_OPTION, 32'hFF);
    // clock enable low must freeze every register
    ce <= 1'h0;
    serial_mode <= 1'h1;
    repeat (3) @(posedge clk);
    chk("frozen", 32'h0, 32'(boot_select));
    ce <= 1'h1;
    serial_mode <= 1'h0;
    @(posedge clk);
    $display("test option done");
    for (int i = 0; i < 8; i++) begin
      bus(1'h1, IDX_CTRL0, 32'h2);
      bus(1'h1, IDX_CTRL0, {29'h0, i[0], 2'h2});
      bus(1'h1, IDX_CTRL1, 32'(i[1]) << (i[2] ? C1_B1DIS : C1_B0DIS));
      prog(i[2] ? BLK1_BASE : BLK0_BASE, 8'($random(seed)),
           i[0] & ~i[1], 1'h0);
    end
    prog(16'h1000, 8'h33, 1'h0, 1'h0);
    $display("test protect done");
    for (int i = 0; i < 4; i++) begin
      f = 1'($random(seed));
      h0 = holds;
      prog(BLKA_BASE | (16'($random(seed)) & 16'h03FF),
           8'($random(seed)), 1'h1, f);
      bus(1'h0, IDX_CMD, 32'h0);
      chk("status", 32'h80, rdat);
      chk("no hold", 32'(h0), 32'(holds));
    end
    bus(1'h1, IDX_CTRL1, 32'h2);
    h0 = holds;
    prog(BLKB_BASE, 8'h5A, 1'h1, 1'h0);
    chk("held", 32'h1, 32'(holds > h0));
    bus(1'h1, IDX_CMD, {24'h0, CMD_STATUS});
    bus(1'h0, IDX_CMD, 32'h0);
    chk("run array", 32'h0, rdat);
    $display("test program done");
    bus(1'h1, IDX_CTRL1, 32'h0);
    bus(1'h1, IDX_CTRL4, 32'h1);
    erase(BLKA_BASE, CMD_CONF);
    bus(1'h1, IDX_CTRL4, 32'h3);
    @(posedge clk);
    chk("suspend", 32'h1, 32'(fm_suspend));
    bus(1'h0, IDX_CTRL0, 32'h0);
    chk("busy", 32'h0, 32'(rdat[C0_READY]));
    bus(1'h0, IDX_CTRL4, 32'h0);
    chk("rd early", 32'h0, 32'(rdat[C4_RDOK]));
    repeat (SUSPEND_CYC) @(posedge clk);
    bus(1'h0, IDX_CTRL4, 32'h0);
    chk("rd ok", 32'h1, 32'(rdat[C4_RDOK]));
    bus(1'h1, IDX_CTRL4, 32'h1);
    wait_rdy();
    chk("eerr", 32'h0, 32'(rdat[C0_EERR]));
    erase(BLKA_BASE, 8'h55);
    bus(1'h0, IDX_CTRL0, 32'h0);
    chk("bad conf", 32'h1, 32'(rdat[C0_EERR]));
    bus(1'h1, IDX_CMD, {24'h0, CMD_CLEAR});
    bus(1'h1, IDX_CTRL1, 32'h2);
    erase(BLKB_BASE, CMD_CONF);
    irq_req <= 1'h1;
    repeat (100) @(posedge clk);
    chk("irq early", 32'h0, 32'(fm_suspend));
    repeat (SUSPEND_CYC) @(posedge clk);
    bus(1'h0, IDX_CTRL4, 32'h0);
    chk("irq susp", 32'h3, {30'h0, rdat[C4_SREQ], fm_suspend});
    irq_req <= 1'h0;
    @(posedge clk);
    bus(1'h1, IDX_CTRL4, 32'h1);
    wait_rdy();
    chk("resumed", 32'h1, 32'(rdat[C0_READY]));
    // lock parallel access, then lift it by erasing the option block
    bus(1'h1, IDX_CTRL1, 32'h0);
    bus(1'h1, IDX_OPTION, 32'h4);
    erase(BLK0_BASE, CMD_CONF);
    chk("locked", 32'h1, 32'(par_access_block));
    wait_rdy();
    chk("kind", 32'h1, 32'(le));
    bus(1'h0, IDX_OPTION, 32'h0);
    chk("unlocked", 32'hFF, rdat);
    chk("lifted", 32'h0, 32'(par_access_block));
    $display("test suspend done");
    for (int k = 0; k < 3; k++) begin
      serial_mode <= 1'h0;
      repeat (3) @(posedge clk);
      flash_blank <= k[1];
      serial_mode <= 1'h1;
      repeat (3) @(posedge clk);
      for (int j = 0; j < 6 && k < 2; j++) begin
        chk("id addr", 32'(ida[j]), 32'(id_rd_addr));
        id_tx(stored(ida[j]) ^ 8'(k == 0 && j == 5));
      end
      chk("accept", 32'(k > 0), 32'(ser_cmd_accept));
    end
    $display("test id done");
    conclude();
  end
endmodule

bind frc_flash_rewrite_control frc_props u_props (.clk(clk), .nrst(nrst),
  .ce(ce), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .paddr(paddr), .fm_start(fm_start), .fm_erase(fm_erase),
  .fm_suspend(fm_suspend), .serial_mode(serial_mode),
  .flash_blank(flash_blank), .ser_cmd_accept(ser_cmd_accept),
  .boot_select(boot_select), .wdt_autostart(wdt_autostart),
  .csp_enable(csp_enable), .fm_addr(fm_addr));
